/* File: common/cfg_pkg.sv */
// Package of constants and carrier types for the converter configuration block.
// Assumes a single 10 MHz system clock; the serial link is sampled, not clocked.
package cfg_pkg;
  // ****************************************************************
  // Configuration register layout
  // ****************************************************************
  localparam int CFG_W = 16;
  localparam logic [15:0] CFG_RESET = 16'h058B;
  localparam int POS_START = 15;
  localparam int POS_MUX_HI = 14;
  localparam int POS_MUX_LO = 12;
  localparam int POS_GAIN_HI = 11;
  localparam int POS_GAIN_LO = 9;
  localparam int POS_MODE = 8;
  localparam int POS_RATE_HI = 7;
  localparam int POS_RATE_LO = 5;
  localparam int POS_TEMP = 4;
  localparam int POS_PULL = 3;
  localparam int POS_KEY_HI = 2;
  localparam int POS_KEY_LO = 1;
  localparam int POS_RSVD = 0;
  localparam logic [1:0] KEY_VALID = 2'h1;
  localparam logic MODE_SINGLE = 1'b1;
  // ****************************************************************
  // Conversion timing
  // ****************************************************************
  localparam int CLK_HZ = 10_000_000;
  // Conversion cycles per rate code: CLK_HZ / rate, rounded down.
  localparam logic [20:0] CONV_CYC_8 = 21'(CLK_HZ / 8);
  localparam logic [20:0] CONV_CYC_16 = 21'(CLK_HZ / 16);
  localparam logic [20:0] CONV_CYC_32 = 21'(CLK_HZ / 32);
  localparam logic [20:0] CONV_CYC_64 = 21'(CLK_HZ / 64);
  localparam logic [20:0] CONV_CYC_128 = 21'(CLK_HZ / 128);
  localparam logic [20:0] CONV_CYC_250 = 21'(CLK_HZ / 250);
  localparam logic [20:0] CONV_CYC_475 = 21'(CLK_HZ / 475);
  localparam logic [20:0] CONV_CYC_860 = 21'(CLK_HZ / 860);
  localparam int FRAME_BITS = 32;
  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [2:0] input_select;
    logic [2:0] gain_range_select;
    logic single_mode;
    logic [2:0] sample_rate_select;
    logic temp_sensor_select;
    logic out_pullup_enable;
  } settings_t;
  typedef struct packed {
    logic [3:0] pos_onehot;
    logic [3:0] neg_onehot;
  } mux_sel_t;
endpackage

/* File: hw/link_sampler.sv */
// Synchroniser and edge finder for the three serial link inputs.
// Assumes the link clock is much slower than sys_clk (10 MHz vs 1.25 MHz).
`timescale 1ns/100ps
`default_nettype none
module link_sampler (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sclk_pin,
  input wire logic cs_b_pin,
  input wire logic din_pin,
  output logic sclk_rise,
  output logic sclk_fall,
  output logic cs_b_sync,
  output logic din_sync
);
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic sclk_prev_ff;

  // Reset values match the idle pins (deselected, link clock low), so that
  // the edge finder cannot report a false edge just after reset.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= 3'h4;
      sync_ff <= 3'h4;
      sclk_prev_ff <= 1'b0;
    end else begin
      meta_ff <= {cs_b_pin, sclk_pin, din_pin};
      sync_ff <= meta_ff;
      sclk_prev_ff <= sync_ff[1];
    end
  end

  assign sclk_rise = sync_ff[1] & ~sclk_prev_ff;
  assign sclk_fall = ~sync_ff[1] & sclk_prev_ff;
  assign cs_b_sync = sync_ff[2];
  assign din_sync = sync_ff[0];
endmodule
`default_nettype wire

/* File: hw/adc_config_register.sv */
// Configuration register of a serial converter with its mode-1 serial slave.
// Assumes the host is a mode-1 serial master; all pins arrive asynchronously.
`timescale 1ns/100ps
`default_nettype none
module adc_config_register (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sclk_pin,
  input wire logic cs_b_pin,
  input wire logic din_pin,
  input wire logic [15:0] conv_result,
  output logic dout_o,
  output logic dout_oe_b,
  output logic pullup_on,
  output cfg_pkg::settings_t settings,
  output cfg_pkg::mux_sel_t mux_sel,
  output logic use_temp_sensor,
  output logic [2:0] full_scale_code,
  output logic converting,
  output logic conv_done
);
  import cfg_pkg::*;

  // ****************************************************************
  // Link sampling
  // ****************************************************************
  logic sclk_rise;
  logic sclk_fall;
  logic cs_b_sync;
  logic din_sync;

  link_sampler u_samp (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .sclk_pin(sclk_pin),
    .cs_b_pin(cs_b_pin),
    .din_pin(din_pin),
    .sclk_rise(sclk_rise),
    .sclk_fall(sclk_fall),
    .cs_b_sync(cs_b_sync),
    .din_sync(din_sync)
  );

  // ****************************************************************
  // Stored settings
  // ****************************************************************
  logic [15:0] cfg_ff;
  logic [15:0] rx_ff;
  logic [5:0] bit_cnt_ff;
  logic [31:0] tx_ff;
  logic dout_ff;
  logic [15:0] echo_ff;
  logic active;
  logic word_done;
  logic [15:0] rx_word;
  logic key_ok;
  logic [15:0] nxt_cfg;
  logic start_req;

  assign active = ~cs_b_sync;
  assign rx_word = {rx_ff[14:0], din_sync};
  assign word_done = active & sclk_fall & (bit_cnt_ff == 6'h0F);
  assign key_ok = rx_word[POS_KEY_HI:POS_KEY_LO] == KEY_VALID;
  // The start bit is never stored, and the reserved bit is forced to one.
  assign nxt_cfg = {1'b0, rx_word[14:1], 1'b1};
  assign start_req = word_done & key_ok & rx_word[POS_START];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff <= CFG_RESET;
    end else if (word_done && key_ok) begin
      cfg_ff <= nxt_cfg;
    end
  end

  // ****************************************************************
  // Serial shifter
  // ****************************************************************
  // Data is sampled on the falling edge and launched on the rising edge.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_ff <= 16'h0000;
      bit_cnt_ff <= 6'h00;
      echo_ff <= 16'h0000;
    end else if (!active) begin
      bit_cnt_ff <= 6'h00;
    end else if (sclk_fall) begin
      rx_ff <= rx_word;
      if (bit_cnt_ff != 6'h3F) begin
        bit_cnt_ff <= bit_cnt_ff + 6'h01;
      end
      if (bit_cnt_ff == 6'h0F) begin
        echo_ff <= key_ok ? nxt_cfg : cfg_ff;
      end
    end
  end

  // Frame is loaded on chip-select fall; readback half is patched after bit 16.
  logic cs_prev_ff;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_prev_ff <= 1'b1;
      tx_ff <= 32'h0000_0000;
      dout_ff <= 1'b1;
    end else begin
      cs_prev_ff <= cs_b_sync;
      if (cs_prev_ff && !cs_b_sync) begin
        tx_ff <= {conv_result, cfg_ff};
      end else if (active && sclk_rise) begin
        if (bit_cnt_ff == 6'h10) begin
          dout_ff <= echo_ff[15];
          tx_ff <= {echo_ff[14:0], 17'h00000};
        end else begin
          dout_ff <= tx_ff[31];
          tx_ff <= {tx_ff[30:0], 1'b0};
        end
      end
    end
  end

  assign dout_o = dout_ff;
  assign dout_oe_b = cs_b_sync;
  assign pullup_on = cs_b_sync & cfg_ff[POS_PULL];

  // ****************************************************************
  // Decoded settings
  // ****************************************************************
  assign settings.input_select = cfg_ff[POS_MUX_HI:POS_MUX_LO];
  assign settings.gain_range_select = cfg_ff[POS_GAIN_HI:POS_GAIN_LO];
  assign settings.single_mode = cfg_ff[POS_MODE];
  assign settings.sample_rate_select = cfg_ff[POS_RATE_HI:POS_RATE_LO];
  assign settings.temp_sensor_select = cfg_ff[POS_TEMP];
  assign settings.out_pullup_enable = cfg_ff[POS_PULL];
  assign use_temp_sensor = cfg_ff[POS_TEMP];
  // Codes 5 to 7 all collapse onto the smallest range.
  assign full_scale_code = (settings.gain_range_select > 3'h4) ? 3'h5
                           : settings.gain_range_select;

  function automatic mux_sel_t mux_decode(input logic [2:0] code);
    mux_sel_t m;
    m = '{pos_onehot: 4'h1, neg_onehot: 4'h2};
    unique case (code)
      3'h0: m = '{pos_onehot: 4'h1, neg_onehot: 4'h2};
      3'h1: m = '{pos_onehot: 4'h1, neg_onehot: 4'h8};
      3'h2: m = '{pos_onehot: 4'h2, neg_onehot: 4'h8};
      3'h3: m = '{pos_onehot: 4'h4, neg_onehot: 4'h8};
      // Pairings for the upper codes are unconfirmed; single-ended is assumed.
      3'h4: m = '{pos_onehot: 4'h1, neg_onehot: 4'h0};
      3'h5: m = '{pos_onehot: 4'h2, neg_onehot: 4'h0};
      3'h6: m = '{pos_onehot: 4'h4, neg_onehot: 4'h0};
      3'h7: m = '{pos_onehot: 4'h8, neg_onehot: 4'h0};
    endcase
    return m;
  endfunction

  assign mux_sel = mux_decode(settings.input_select);

  function automatic logic [20:0] rate_cycles(input logic [2:0] code);
    logic [20:0] c;
    c = CONV_CYC_128;
    unique case (code)
      3'h0: c = CONV_CYC_8;
      3'h1: c = CONV_CYC_16;
      3'h2: c = CONV_CYC_32;
      3'h3: c = CONV_CYC_64;
      3'h4: c = CONV_CYC_128;
      3'h5: c = CONV_CYC_250;
      3'h6: c = CONV_CYC_475;
      3'h7: c = CONV_CYC_860;
    endcase
    return c;
  endfunction

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01
  } conv_state_t;
  conv_state_t state_ff;
  logic [20:0] conv_cnt_ff;
  logic [20:0] conv_len;
  logic conv_end;
  logic begin_conv;

  assign conv_len = rate_cycles(settings.sample_rate_select);
  assign conv_end = (state_ff == ST_CONV) && (conv_cnt_ff >= conv_len - 21'h1);
  // A start while converting is dropped, never held for later.
  assign begin_conv = (state_ff == ST_IDLE)
                      && (!settings.single_mode || start_req);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      conv_cnt_ff <= 21'h000000;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          conv_cnt_ff <= 21'h000000;
          if (begin_conv) begin
            state_ff <= ST_CONV;
          end
        end
        ST_CONV: begin
          conv_cnt_ff <= conv_cnt_ff + 21'h000001;
          if (conv_end) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  assign converting = (state_ff == ST_CONV);
  assign conv_done = conv_end;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_RESERVED_ONE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg_ff[POS_RSVD] == 1'b1) else $error("Reserved bit not one.");
  AST_START_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg_ff[POS_START] == 1'b0) else $error("Start bit stored.");
  AST_BAD_KEY: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (word_done && !key_ok) |=> $stable(cfg_ff)) else $error("Bad key changed register.");
  AST_GOOD_KEY: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (word_done && key_ok) |=> cfg_ff[14:1] == $past(rx_word[14:1]))
    else $error("Valid word not stored.");
  AST_NO_QUEUE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!converting && settings.single_mode && !start_req) |=> !converting)
    else $error("Start queued.");
  AST_SINGLE_START: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!converting && start_req) |=> converting) else $error("Single start missed.");
  AST_SINGLE_STOPS: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (conv_end && settings.single_mode && !word_done)
    |=> !converting ##1 (!converting || $past(start_req)))
    else $error("Single mode kept converting.");
  AST_PULLUP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    pullup_on == (cs_b_sync && cfg_ff[POS_PULL])) else $error("Pullup wrong.");
  AST_GAIN_TOP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (settings.gain_range_select >= 3'h5) |-> full_scale_code == 3'h5)
    else $error("Gain collapse wrong.");
endmodule
`default_nettype wire

/* File: testbench/spi_host_model.sv */
// Serial master model that plays the host on the far side of the block.
// Assumes a 10 MHz sys_clk; the link clock has an 800 ns period and idles low.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  input wire logic sys_clk,
  input wire logic dout_o,
  input wire logic dout_oe_b,
  input wire logic pullup_on,
  output logic sclk_pin,
  output logic cs_b_pin,
  output logic din_pin,
  output logic [31:0] rx_word,
  output logic rx_valid
);
  // ****************************************************************
  // Data line and frame driver
  // ****************************************************************
  logic last_bit;
  wire logic line;
  // A floating line shows one with the pullup on, else the inverse of its last bit, so stale data never passes unpulled.
  assign line = !dout_oe_b ? dout_o : (pullup_on ? 1'b1 : !last_bit);
  initial begin
    sclk_pin = 1'b0;
    cs_b_pin = 1'b1;
    din_pin = 1'b0;
    rx_word = 32'h0;
    rx_valid = 1'b0;
    last_bit = 1'b0;
  end
  task automatic frame(input logic [31:0] tx);
    @(negedge sys_clk);
    cs_b_pin = 1'b0;
    repeat (4) @(negedge sys_clk);
    for (int k = 31; k >= 0; k--) begin
      sclk_pin = 1'b1;
      din_pin = tx[k];
      repeat (4) @(negedge sys_clk);
      rx_word = {rx_word[30:0], line};
      last_bit = rx_word[0];
      sclk_pin = 1'b0;
      repeat (4) @(negedge sys_clk);
    end
    cs_b_pin = 1'b1;
    rx_valid = 1'b1;
    @(negedge sys_clk);
    rx_valid = 1'b0;
    repeat (8) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

/* File: testbench/adc_config_register_tb_top.sv */
// Self-checking bench for the converter configuration register.
// Assumes spi_host_model plays the serial master on the far side.
`timescale 1ns/100ps
`default_nettype none
module adc_config_register_tb_top;
  import cfg_pkg::*;
  // ****************************************************************
  // Harness
  // ****************************************************************
  logic sys_clk, rst_b, sclk_pin, cs_b_pin, din_pin, dout_o, dout_oe_b, pullup_on;
  logic converting, conv_done, use_temp_sensor, rx_valid;
  logic [15:0] conv_result, reg_m;
  logic [31:0] rx_word;
  logic [2:0] full_scale_code;
  settings_t settings;
  mux_sel_t mux_sel;
  logic [31:0] exp_q[$];
  int errors, cmp_count, done_cnt, i, n;
  adc_config_register adc_config_register_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .sclk_pin(sclk_pin), .cs_b_pin(cs_b_pin), .din_pin(din_pin),
    .conv_result(conv_result), .dout_o(dout_o), .dout_oe_b(dout_oe_b),
    .pullup_on(pullup_on), .settings(settings), .mux_sel(mux_sel),
    .use_temp_sensor(use_temp_sensor), .full_scale_code(full_scale_code),
    .converting(converting), .conv_done(conv_done));
  spi_host_model spi_host_model_i (.sys_clk(sys_clk), .dout_o(dout_o),
    .dout_oe_b(dout_oe_b), .pullup_on(pullup_on), .sclk_pin(sclk_pin),
    .cs_b_pin(cs_b_pin), .din_pin(din_pin), .rx_word(rx_word), .rx_valid(rx_valid));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Each finished frame takes the oldest expected readback off the queue.
  always @(posedge sys_clk) begin
    if (rx_valid === 1'b1) begin
      chk("readback", exp_q.size() ? exp_q.pop_front() : 32'hX, rx_word);
    end
    if (conv_done === 1'b1) begin
      done_cnt++;
    end
  end
  task automatic check_outs();
    logic [2:0] m;
    logic [3:0] p, q;
    m = reg_m[14:12];
    p = m[2] ? (4'h1 << m[1:0]) : (4'h1 << ((m == 3'h0) ? 2'h0 : m[1:0] - 2'h1));
    q = m[2] ? 4'h0 : ((m == 3'h0) ? 4'h2 : 4'h8);
    chk("settings", 32'(reg_m[14:3]), 32'(settings));
    chk("full_scale_code", (reg_m[11:9] > 3'h5) ? 32'h5 : 32'(reg_m[11:9]), 32'(full_scale_code));
    chk("use_temp_sensor", 32'(reg_m[4]), 32'(use_temp_sensor));
    chk("pullup_on", 32'(reg_m[3]), 32'(pullup_on));
    chk("mux_sel", 32'({p, q}), 32'(mux_sel));
  endtask
  task automatic xfer(input logic [15:0] w);
    conv_result = 16'($urandom);
    if (w[2:1] == 2'h1) begin
      reg_m = {1'b0, w[14:1], 1'b1};
    end
    exp_q.push_back({conv_result, reg_m});
    spi_host_model_i.frame({w, w});
    check_outs();
  endtask
  task automatic wait_conv(input logic lvl);
    for (n = 0; n < 20000 && converting !== lvl; n++) begin
      @(negedge sys_clk);
    end
    if (converting !== lvl) begin
      errors++;
      $display("Error converting expected %b seen %b", lvl, converting);
      stop_test();
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    void'($urandom(16637));
    rst_b = 1'b0;
    conv_result = 16'h0000;
    reg_m = 16'h058B;
    errors = 0;
    cmp_count = 0;
    done_cnt = 0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge sys_clk);
    check_outs();
    xfer(16'h0000);
    xfer(16'hFFFF);
    xfer((16'($urandom) & 16'h7EF9) | 16'h0104);
    for (i = 0; i < 8; i++) begin
      xfer({1'b0, i[2:0], i[2:0], 1'b1, i[2:0], 2'($urandom), 2'h1, 1'($urandom)});
    end
    // Even the fastest rate keeps the conversion long enough to overlap a second start.
    done_cnt = 0;
    xfer(16'h81EA);
    chk("converting", 32'h1, 32'(converting));
    xfer(16'h81EA);
    wait_conv(1'b0);
    repeat (300) @(negedge sys_clk);
    chk("conv_done count", 32'h1, done_cnt);
    chk("converting", 32'h0, 32'(converting));
    xfer(16'h01EA);
    repeat (20) @(negedge sys_clk);
    chk("converting", 32'h0, 32'(converting));
    done_cnt = 0;
    xfer(16'h00EA);
    repeat (30000) @(negedge sys_clk);
    chk("continuous", 32'h2, done_cnt);
    stop_test();
  end
endmodule
`default_nettype wire
